// ===== rtl/fspd_pkg.sv
// Constants, encodings and stage carriers of the five-stage pipeline.
// Assumes one clock; all users import the whole package.
package fspd_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    // Pipeline clock runs four times the external master clock
    localparam int PCLK_PER_MCLK = 4;
    // Two phases per pipeline cycle, one CLK_I edge each
    localparam int PHASES        = 2;

    // ------------------------------------------------------------
    // Fetch and addresses
    // ------------------------------------------------------------
    localparam int          IDX_W       = 11;
    localparam int          TAG_W       = 20;
    localparam logic [63:0] PC_STEP     = 64'h4;
    localparam logic [63:0] BOOT_VECTOR = 64'h0000_0000_0000_0000;
    localparam logic [63:0] EXC_VECTOR  = 64'h0000_0000_0000_0180;
    localparam logic [4:0]  LINK_REG    = 5'h1f;
    localparam logic [4:0]  TRAP_CAUSE  = 5'h0d;

    // ------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] OPC_BEQ     = 6'h04;
    localparam logic [5:0] OPC_LOAD    = 6'h23;
    localparam logic [5:0] OPC_STORE   = 6'h2b;
    localparam logic [5:0] FN_ADD      = 6'h20;
    localparam logic [5:0] FN_JUMP_LINK_REGISTER_OP     = 6'h09;
    localparam logic [5:0] FN_TLT      = 6'h32;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] EPC_LO_OFS = 8'h08;
    localparam logic [7:0] EPC_HI_OFS = 8'h0c;
    localparam int         CTRL_RUN   = 0;
    localparam int         CTRL_CLR   = 1;
    localparam logic       RUN_RST    = 1'b1;
    localparam int         ST_EXL     = 0;
    localparam int         ST_BD      = 1;
    localparam int         ST_CAUSE   = 2;
    localparam int         ST_PHASE   = 8;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD,
        OP_JUMP_LINK_REGISTER_OP,
        OP_BEQ,
        OP_TLT,
        OP_LW,
        OP_SW
    } fspd_op_t;

    typedef struct packed {
        logic        valid;
        fspd_op_t    op;
        logic        wr;
        logic [4:0]  dst;
        logic        bd;
        logic        exc;
        logic [63:0] pc;
    } fspd_ctl_t;

    typedef struct packed {
        logic        valid;
        logic        bd;
        logic [63:0] pc;
        logic [31:0] ins;
    } fspd_fetch_t;

    typedef struct packed {
        fspd_ctl_t   c;
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] link;
        logic [15:0] imm;
    } fspd_exec_t;

    typedef struct packed {
        fspd_ctl_t   c;
        logic [63:0] res;
        logic [63:0] sd;
        logic        hit;
    } fspd_mem_t;

endpackage : fspd_pkg

// ===== rtl/fspd_regs.sv
// General register file: two read ports, one write port.
// Assumes the writer strobes only in the first phase of a cycle.
module fspd_regs
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Read ports
    input  wire logic [4:0]  ra_i,
    input  wire logic [4:0]  rb_i,
    output logic      [63:0] da_o,
    output logic      [63:0] db_o,
    // Write port
    input  wire logic        we_i,
    input  wire logic [4:0]  wa_i,
    input  wire logic [63:0] wd_i
);
    import fspd_pkg::*;

    logic [63:0] mem [32];

    // Register zero always reads zero
    assign da_o = (ra_i == 5'h00) ? 64'h0 : mem[ra_i];
    assign db_o = (rb_i == 5'h00) ? 64'h0 : mem[rb_i];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 32; i++)
            begin
                mem[i] <= 64'h0;
            end
        end
        else if (we_i)
        begin
            mem[wa_i] <= wd_i;
        end
    end

endmodule : fspd_regs

// ===== rtl/fspd_core.sv
// Five-stage integer pipeline with register access over APB.
// Assumes caches answer in the same clock; misses, slips and the
// wider exception logic live outside this block.
//
// Notes on behaviour
// - Fetch phase one indexes the instruction cache with pc low 11 bits.
// - Fetch phase two checks tag, reads word, advances pc by four.
// - Operand read phase two reads rs and rt from two-port file.
// - Bypass picks execute result, data-cache result or file value.
// - Add sums operands; result latched in execute phase one.
// - Data-cache stage just passes the add result onward.
// - Writeback phase one writes result to destination with strobe.
// - Jump-link-register loads rs value as next fetch address.
// - Link address is pc plus eight, carried down to writeback.
// - Link goes to register 31 when no destination; rd equal rs undefined.
// - Branch-if-equal compares operands; taken goes to pc plus four plus offset times four.
// - Branch target ready for fetch next cycle; later stages idle.
// - Trap subtracts; less-than from operand and result sign bits.
// - Taken trap loads vector and kills younger instructions.
// - Trap writeback sets return address, cause, delay flag, level bit.
// - Untaken trap does nothing in writeback.
// - Load address is bypassed base plus offset, latched phase one.
// - Load checks data tag, aligns data, latches it in phase two.
// - Load writes aligned data to target register in phase one.
// - Store aligns bypassed data in shifter; address phase one.
// - Store checks tag and latches store data in phase one.
// - Store writes data cache in writeback on a hit.
// - Store holds cache two cycles; next cache user stalls one.
// - Each stage takes one pipeline cycle of two phases.
// - One delay slot follows every branch or jump.
module fspd_core
(
    // Clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RST_N_I,
    // APB slave
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [7:0]                PADDR_I,
    input  wire logic [31:0]               PWDATA_I,
    output logic      [31:0]               PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,
    // Instruction cache
    output logic      [fspd_pkg::IDX_W-1:0] IC_INDEX_O,
    input  wire logic [31:0]               IC_WORD_I,
    input  wire logic [fspd_pkg::TAG_W-1:0] IC_TAG_I,
    input  wire logic [fspd_pkg::TAG_W-1:0] IC_PFN_I,
    output logic                           IC_MISS_O,
    // Data cache
    output logic      [63:0]               DC_RADDR_O,
    input  wire logic [63:0]               DC_RDATA_I,
    input  wire logic [fspd_pkg::TAG_W-1:0] DC_TAG_I,
    input  wire logic [fspd_pkg::TAG_W-1:0] DC_PFN_I,
    output logic      [63:0]               DC_WADDR_O,
    output logic      [63:0]               DC_WDATA_O,
    output logic                           DC_WE_O,
    // Exception state
    output logic      [63:0]               EPC_O,
    output logic                           EXL_O
);
    import fspd_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [63:0] sext16(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction : sext16

    function automatic fspd_op_t decode(input logic [31:0] w);
        fspd_op_t o;
        o = OP_NOP;
        if (w[31:26] == OPC_SPECIAL)
        begin
            if (w[5:0] == FN_ADD)
                o = OP_ADD;
            else if (w[5:0] == FN_JUMP_LINK_REGISTER_OP)
                o = OP_JUMP_LINK_REGISTER_OP;
            else if (w[5:0] == FN_TLT)
                o = OP_TLT;
        end
        else if (w[31:26] == OPC_BEQ)
            o = OP_BEQ;
        else if (w[31:26] == OPC_LOAD)
            o = OP_LW;
        else if (w[31:26] == OPC_STORE)
            o = OP_SW;
        return o;
    endfunction : decode

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic        run;
    logic        ph;
    logic [63:0] pc;
    fspd_fetch_t rf_q;
    fspd_exec_t  ex_q;
    fspd_mem_t   dc_q;
    fspd_mem_t   wb_q;
    logic [63:0] ex_alu;
    logic [63:0] ex_sh;
    logic        dc_hit;
    logic [63:0] dc_st;
    logic [63:0] exception_return_address;
    logic [4:0]  cause;
    logic        bd_flag;
    logic        exception_level_bit;
    logic [31:0] prdata;
    logic        rf_we;

    // ------------------------------------------------------------
    // Phase and advance
    // ------------------------------------------------------------
    wire adv     = run & ph;
    wire ph1     = run & ~ph;
    wire dc_user = dc_q.c.valid
                   & (dc_q.c.op == OP_LW | dc_q.c.op == OP_SW);
    // Second cache cycle of a store blocks the next cache user
    wire stall   = wb_q.c.valid & wb_q.c.op == OP_SW & dc_user;
    wire adv_up  = adv & ~stall;

    // ------------------------------------------------------------
    // Operand read stage
    // ------------------------------------------------------------
    wire [4:0]  rs_a = rf_q.ins[25:21];
    wire [4:0]  rt_a = rf_q.ins[20:16];
    wire [4:0]  rd_a = rf_q.ins[15:11];
    wire [63:0] rf_da;
    wire [63:0] rf_db;
    fspd_op_t   rf_op;
    assign rf_op = decode(rf_q.ins);

    // Load results reach here only as addresses; interlock is outside.
    // Later stages come in as arguments so the assigns see them change.
    function automatic logic [63:0] fwd(input logic [4:0]  r,
                                        input logic [63:0] v,
                                        input fspd_ctl_t   xc,
                                        input logic [63:0] xv,
                                        input fspd_ctl_t   mc,
                                        input logic [63:0] mv);
        if (r != 5'h00 && xc.valid && xc.wr && xc.dst == r)
            return xv;
        else if (r != 5'h00 && mc.valid && mc.wr && mc.dst == r)
            return mv;
        return v;
    endfunction : fwd

    wire [63:0] rs_val = fwd(rs_a, rf_da, ex_q.c, ex_alu,
                             dc_q.c, dc_q.res);
    wire [63:0] rt_val = fwd(rt_a, rf_db, ex_q.c, ex_alu,
                             dc_q.c, dc_q.res);
    wire        br_eq  = (rs_val == rt_val);
    wire [63:0] pc_adv = rf_q.pc + PC_STEP;
    wire [63:0] link   = pc_adv + PC_STEP;
    wire [63:0] br_off = sext16(rf_q.ins[15:0]);
    wire [63:0] br_tgt = pc_adv + {br_off[61:0], 2'b00};
    wire        is_jr  = rf_q.valid & rf_op == OP_JUMP_LINK_REGISTER_OP;
    wire        is_br  = rf_q.valid & rf_op == OP_BEQ;
    wire        redir  = is_jr | (is_br & br_eq);
    wire [63:0] target = is_jr ? rs_val : br_tgt;
    wire        rf_wr  = rf_op == OP_ADD | rf_op == OP_JUMP_LINK_REGISTER_OP
                         | rf_op == OP_LW;
    wire [4:0]  jr_dst = (rd_a == 5'h00) ? LINK_REG : rd_a;
    wire [4:0]  rf_dst = (rf_op == OP_LW) ? rt_a
                         : (rf_op == OP_JUMP_LINK_REGISTER_OP) ? jr_dst : rd_a;

    fspd_regs fspd_regs_inst
    (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .ra_i    (rs_a),
        .rb_i    (rt_a),
        .da_o    (rf_da),
        .db_o    (rf_db),
        .we_i    (rf_we),
        .wa_i    (wb_q.c.dst),
        .wd_i    (wb_q.res)
    );

    // ------------------------------------------------------------
    // Execute stage
    // ------------------------------------------------------------
    logic [63:0] alu;
    always_comb
    begin
        case (ex_q.c.op)
            OP_TLT:  alu = ex_q.a - ex_q.b;
            OP_LW,
            OP_SW:   alu = ex_q.a + sext16(ex_q.imm);
            OP_JUMP_LINK_REGISTER_OP: alu = ex_q.link;
            default: alu = ex_q.a + ex_q.b;
        endcase
    end

    wire lt        = (ex_q.a[63] ^ ex_q.b[63]) ? ex_q.a[63]
                     : ex_alu[63];
    wire trap_hit  = ex_q.c.valid & ex_q.c.op == OP_TLT & lt;
    wire trap_take = adv_up & trap_hit;

    // ------------------------------------------------------------
    // Data-cache and writeback stages
    // ------------------------------------------------------------
    wire [31:0] ld_word = dc_q.res[2] ? DC_RDATA_I[63:32]
                          : DC_RDATA_I[31:0];
    wire [63:0] ld_data = {{32{ld_word[31]}}, ld_word};
    wire        wb_ph1  = ph1 & wb_q.c.valid;
    assign rf_we = wb_ph1 & wb_q.c.wr;
    wire        trap_wb = wb_ph1 & wb_q.c.exc;
    wire        ic_hit  = (IC_TAG_I == IC_PFN_I);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    wire acc      = PSEL_I & PENABLE_I;
    wire bus_wr   = acc & PWRITE_I;
    wire hit_ctrl = PADDR_I == CTRL_OFS;
    wire hit_stat = PADDR_I == STATUS_OFS;
    wire hit_epcl = PADDR_I == EPC_LO_OFS;
    wire hit_epch = PADDR_I == EPC_HI_OFS;
    wire hit_any  = hit_ctrl | hit_stat | hit_epcl | hit_epch;
    wire exl_clr  = bus_wr & hit_ctrl & PWDATA_I[CTRL_CLR];

    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = 32'h0;
        if (hit_ctrl)
            next_prdata[CTRL_RUN] = run;
        else if (hit_stat)
        begin
            next_prdata[ST_EXL]              = exception_level_bit;
            next_prdata[ST_BD]               = bd_flag;
            next_prdata[ST_CAUSE+:5]         = cause;
            next_prdata[ST_PHASE]            = ph;
        end
        else if (hit_epcl)
            next_prdata = exception_return_address[31:0];
        else if (hit_epch)
            next_prdata = exception_return_address[63:32];
    end

    // Read data captured in setup so it stands through the access
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            prdata <= 32'h0;
        else if (PSEL_I & ~PENABLE_I)
            prdata <= next_prdata;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            run <= RUN_RST;
        else if (bus_wr & hit_ctrl)
            run <= PWDATA_I[CTRL_RUN];
    end

    // ------------------------------------------------------------
    // Pipeline registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ph <= 1'b0;
        else if (run)
            ph <= ~ph;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pc   <= BOOT_VECTOR;
            rf_q <= '0;
            ex_q <= '0;
            dc_q <= '0;
        end
        else if (adv_up)
        begin
            if (trap_take)
                pc <= EXC_VECTOR;
            else if (redir)
                pc <= target;
            else
                pc <= pc + PC_STEP;
            rf_q <= '{valid: ~trap_take, bd: is_jr | is_br,
                      pc: pc, ins: IC_WORD_I};
            ex_q <= '{c: '{valid: rf_q.valid & ~trap_take, op: rf_op,
                           wr: rf_wr, dst: rf_dst, bd: rf_q.bd,
                           exc: 1'b0, pc: rf_q.pc},
                      a: rs_val, b: rt_val, link: link,
                      imm: rf_q.ins[15:0]};
            dc_q <= '{c: '{valid: ex_q.c.valid, op: ex_q.c.op,
                           wr: ex_q.c.wr, dst: ex_q.c.dst,
                           bd: ex_q.c.bd, exc: trap_hit,
                           pc: ex_q.c.pc},
                      res: ex_alu, sd: ex_sh, hit: 1'b0};
        end
    end

    // Store occupies the cache one more cycle: writeback gets a bubble
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            wb_q <= '0;
        else if (adv & stall)
            wb_q <= '0;
        else if (adv_up)
            wb_q <= '{c: dc_q.c,
                      res: (dc_q.c.op == OP_LW) ? ld_data : dc_q.res,
                      sd: dc_st, hit: dc_hit};
    end

    // Phase one latches: ALU output, data tag check, store data
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ex_alu <= 64'h0;
            dc_hit <= 1'b0;
            dc_st  <= 64'h0;
        end
        else if (ph1)
        begin
            ex_alu <= alu;
            dc_hit <= (DC_TAG_I == DC_PFN_I);
            dc_st  <= ex_sh;
        end
    end

    // Phase two latch: store data in both word lanes; held in a stall
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ex_sh <= 64'h0;
        else if (adv_up)
            ex_sh <= {ex_q.b[31:0], ex_q.b[31:0]};
    end

    // Exception state; a trap in the clear cycle keeps the level bit
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            exception_return_address     <= 64'h0;
            cause   <= 5'h00;
            bd_flag <= 1'b0;
            exception_level_bit     <= 1'b0;
        end
        else if (trap_wb)
        begin
            exception_return_address     <= wb_q.c.pc;
            cause   <= TRAP_CAUSE;
            bd_flag <= wb_q.c.bd;
            exception_level_bit     <= 1'b1;
        end
        else if (exl_clr)
            exception_level_bit <= 1'b0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA_O   = prdata;
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = acc & ~hit_any;
    assign IC_INDEX_O = pc[IDX_W-1:0];
    assign IC_MISS_O  = adv & ~ic_hit;
    assign DC_RADDR_O = dc_q.res;
    assign DC_WADDR_O = wb_q.res;
    assign DC_WDATA_O = wb_q.sd;
    assign DC_WE_O    = wb_ph1 & wb_q.c.op == OP_SW & wb_q.hit;
    assign EPC_O      = exception_return_address;
    assign EXL_O      = exception_level_bit;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_pc_step:
    assert property (adv_up & ~trap_take & ~redir
                     |=> pc == $past(pc) + PC_STEP)
        else $error("pc did not step by four");

    a_rf_write:
    assert property (rf_we |-> ~ph ##1 ~rf_we)
        else $error("register write outside one phase");

    a_trap_vec:
    assert property (trap_take |=> pc == EXC_VECTOR && !rf_q.valid
                     && !ex_q.c.valid)
        else $error("trap did not redirect and kill");

    a_trap_state:
    assert property (trap_wb |=> exception_level_bit && exception_return_address == $past(wb_q.c.pc)
                     && cause == TRAP_CAUSE)
        else $error("trap state not recorded");

    a_link_addr:
    assert property (ex_q.c.valid && ex_q.c.op == OP_JUMP_LINK_REGISTER_OP
                     |-> ex_q.link == ex_q.c.pc + 64'h8)
        else $error("link address wrong");

    a_store_bubble:
    assert property (adv & stall |=> !wb_q.c.valid && $stable(pc)
                     && $stable(dc_q))
        else $error("store stall not one cycle");

    a_branch_go:
    assert property (adv_up & ~trap_take & redir
                     |=> pc == $past(target))
        else $error("branch target not taken");

    a_empty_quiet:
    assert property (!wb_q.c.valid |-> !rf_we && !DC_WE_O)
        else $error("write from empty writeback");

    a_cache_write:
    assert property (DC_WE_O |-> wb_q.hit && ~ph && wb_q.c.op == OP_SW)
        else $error("data cache write without hit");

    c_trap: cover property (trap_take ##[2:8] trap_wb);
    c_stall: cover property (adv & stall);
    c_jump: cover property (adv_up & is_jr);
    c_load: cover property (rf_we & wb_q.c.op == OP_LW);

endmodule : fspd_core

// ===== test/fspd_cache_model.sv
// Behavioural instruction and data caches facing the pipeline.
// Assumes the bench preloads both arrays before reset is released.
module fspd_cache_model
(
    // Clock
    input  wire logic        clk_i,
    // Instruction side
    input  wire logic [fspd_pkg::IDX_W-1:0] ic_index_i,
    output logic      [31:0] ic_word_o,
    output logic      [fspd_pkg::TAG_W-1:0] ic_tag_o,
    output logic      [fspd_pkg::TAG_W-1:0] ic_pfn_o,
    // Data side
    input  wire logic [63:0] dc_raddr_i,
    output logic      [63:0] dc_rdata_o,
    output logic      [fspd_pkg::TAG_W-1:0] dc_tag_o,
    output logic      [fspd_pkg::TAG_W-1:0] dc_pfn_o,
    input  wire logic [63:0] dc_waddr_i,
    input  wire logic [63:0] dc_wdata_i,
    input  wire logic        dc_we_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import fspd_pkg::*;
    // Arbitrary page frame; tags always match, so every access hits
    localparam logic [TAG_W-1:0] PAGE = 20'h00001;
    logic [31:0] imem [512];
    logic [63:0] dmem [256];
    assign ic_word_o  = imem[ic_index_i[10:2]];
    assign ic_tag_o   = PAGE;
    assign ic_pfn_o   = PAGE;
    assign dc_rdata_o = dmem[dc_raddr_i[10:3]];
    assign dc_tag_o   = PAGE;
    assign dc_pfn_o   = PAGE;
    // Plain always: the bench also fills this array
    always @(posedge clk_i)
    begin
        // Word store: only the addressed half of the line changes
        if (dc_we_i === 1'b1 && dc_waddr_i[2])
            dmem[dc_waddr_i[10:3]][63:32] <= dc_wdata_i[63:32];
        else if (dc_we_i === 1'b1)
            dmem[dc_waddr_i[10:3]][31:0] <= dc_wdata_i[31:0];
    end
endmodule : fspd_cache_model

// ===== test/tb.sv
// Bench: runs a small program through the pipeline and checks stores,
// trap state and registers. Assumes the cache model answers at once.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fspd_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ic_miss, dc_we, exception_level_bit, er;
    logic [IDX_W-1:0] ic_index;
    logic [31:0] ic_word;
    logic [TAG_W-1:0] ic_tag, ic_pfn, dc_tag, dc_pfn;
    logic [63:0] dc_raddr, dc_rdata, dc_waddr, dc_wdata, exception_return_address;
    int fail_count = 0, n_checks = 0;

    always #5 clk = ~clk;

    fspd_core fspd_core_inst (.CLK_I(clk), .RST_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr),
        .IC_INDEX_O(ic_index), .IC_WORD_I(ic_word), .IC_TAG_I(ic_tag),
        .IC_PFN_I(ic_pfn), .IC_MISS_O(ic_miss), .DC_RADDR_O(dc_raddr),
        .DC_RDATA_I(dc_rdata), .DC_TAG_I(dc_tag), .DC_PFN_I(dc_pfn),
        .DC_WADDR_O(dc_waddr), .DC_WDATA_O(dc_wdata), .DC_WE_O(dc_we),
        .EPC_O(exception_return_address), .EXL_O(exception_level_bit));

    fspd_cache_model fspd_cache_model_inst (.clk_i(clk),
        .ic_index_i(ic_index), .ic_word_o(ic_word), .ic_tag_o(ic_tag),
        .ic_pfn_o(ic_pfn), .dc_raddr_i(dc_raddr), .dc_rdata_o(dc_rdata),
        .dc_tag_o(dc_tag), .dc_pfn_o(dc_pfn), .dc_waddr_i(dc_waddr),
        .dc_wdata_i(dc_wdata), .dc_we_i(dc_we));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] r_ins(input logic [4:0] s, t, d,
                                          input logic [5:0] f);
        return {OPC_SPECIAL, s, t, d, 5'h00, f};
    endfunction : r_ins

    function automatic logic [31:0] i_ins(input logic [5:0] o,
        input logic [4:0] s, t, input logic [15:0] m);
        return {o, s, t, m};
    endfunction : i_ins

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Program and checks
    // ------------------------------------------------------------
    initial
    begin
        foreach (fspd_cache_model_inst.imem[k])
            fspd_cache_model_inst.imem[k] = 32'h0;
        foreach (fspd_cache_model_inst.dmem[k])
            fspd_cache_model_inst.dmem[k] = 64'h0;
        fspd_cache_model_inst.dmem[1] = 64'h0000_0005_0000_0003;
        fspd_cache_model_inst.dmem[2] = 64'h0000_0000_0000_0040;
        fspd_cache_model_inst.imem[0] = i_ins(OPC_LOAD, 0, 1, 16'h8);
        fspd_cache_model_inst.imem[1] = i_ins(OPC_LOAD, 0, 2, 16'hc);
        fspd_cache_model_inst.imem[2] = i_ins(OPC_LOAD, 0, 6, 16'h10);
        fspd_cache_model_inst.imem[4] = r_ins(1, 2, 3, FN_ADD);
        fspd_cache_model_inst.imem[5] = r_ins(3, 3, 4, FN_ADD);
        fspd_cache_model_inst.imem[6] = i_ins(OPC_STORE, 0, 4, 16'h20);
        fspd_cache_model_inst.imem[7] = i_ins(OPC_BEQ, 1, 1, 16'h4);
        fspd_cache_model_inst.imem[8] = i_ins(OPC_STORE, 0, 3, 16'h28);
        fspd_cache_model_inst.imem[9] = i_ins(OPC_STORE, 0, 1, 16'h30);
        fspd_cache_model_inst.imem[12] = r_ins(6, 0, 0, FN_JUMP_LINK_REGISTER_OP);
        fspd_cache_model_inst.imem[13] = i_ins(OPC_STORE, 0, 2, 16'h3c);
        fspd_cache_model_inst.imem[14] = i_ins(OPC_STORE, 0, 1, 16'h50);
        fspd_cache_model_inst.imem[16] = i_ins(OPC_STORE, 0, 31, 16'h48);
        fspd_cache_model_inst.imem[17] = r_ins(2, 1, 0, FN_TLT);
        fspd_cache_model_inst.imem[18] = r_ins(1, 2, 0, FN_TLT);
        fspd_cache_model_inst.imem[19] = i_ins(OPC_STORE, 0, 1, 16'h58);
        fspd_cache_model_inst.imem[96] = i_ins(OPC_STORE, 0, 2, 16'h60);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h1)
        // Last store of the run is the one in the trap handler
        do @(negedge clk); while (!(dc_we === 1'b1 && dc_waddr === 64'h60));
        repeat (2) @(posedge clk);
        `CHK(fspd_cache_model_inst.dmem[4], 64'h10)
        `CHK(fspd_cache_model_inst.dmem[5], 64'h8)
        `CHK(fspd_cache_model_inst.dmem[6], 64'h0)
        `CHK(fspd_cache_model_inst.dmem[7], 64'h5_0000_0000)
        `CHK(fspd_cache_model_inst.dmem[9], 64'h38)
        `CHK(fspd_cache_model_inst.dmem[10], 64'h0)
        `CHK(fspd_cache_model_inst.dmem[11], 64'h0)
        `CHK(fspd_cache_model_inst.dmem[12], 64'h5)
        `CHK(ic_miss, 1'b0)
        `CHK(exception_return_address, 64'h48)
        `CHK(exception_level_bit, 1'b1)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd & 32'hff, {25'h0, TRAP_CAUSE, 2'b01})
        apb(1'b0, EPC_LO_OFS, 32'h0);
        `CHK(rd, 32'h48)
        apb(1'b1, CTRL_OFS, 32'h3);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(exception_level_bit, 1'b0)
        // Unmapped place: error flagged, nothing read back
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        end_of_test();
    end
endmodule : tb
